// ### common/oesb_defs.vh
// Constants for the output enable and sideband control block
`ifndef OESB_DEFS_VH
`define OESB_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OESB_IDX_EN0      8'h00
`define OESB_IDX_EN1      8'h01
`define OESB_IDX_EN2      8'h02
`define OESB_IDX_MODE     8'h04
`define OESB_IDX_MASK0    8'h08
`define OESB_IDX_MASK1    8'h09
`define OESB_IDX_MASK2    8'h0a

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define OESB_NUM_OUT      20
`define OESB_MODE_BIT     0
`define OESB_PIN_LO       5
`define OESB_PIN_HI       12
`define OESB_PIN_DATA     5
`define OESB_PIN_CLK      6
`define OESB_PIN_LOAD     10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OESB_RST_EN       20'hfffff
`define OESB_RST_OUTREG   20'hfffff
`define OESB_RST_MASK     20'h00000
`define OESB_RST_SHIFT    20'h00000
`define OESB_RST_ADDR     8'h00
`define OESB_RST_PINS     8'h00
`define OESB_RST_SEL      1'b0
`define OESB_RST_PG       1'b0
`define OESB_RST_STRAP    4'h0
`define OESB_RST_LEVEL    1'b0

// ----------------------------------------------------------------
// Three-level strap codes
// ----------------------------------------------------------------
`define OESB_STRAP_L      2'h0
`define OESB_STRAP_M      2'h1
`define OESB_STRAP_H      2'h2

// ----------------------------------------------------------------
// Slave addresses by strap pair (high, low)
// ----------------------------------------------------------------
`define OESB_ADDR_LL      8'hd8
`define OESB_ADDR_LM      8'hda
`define OESB_ADDR_LH      8'hde
`define OESB_ADDR_ML      8'hc2
`define OESB_ADDR_MM      8'hc4
`define OESB_ADDR_MH      8'hc6
`define OESB_ADDR_HL      8'hca
`define OESB_ADDR_HM      8'hcc
`define OESB_ADDR_HH      8'hce

`endif

// ### rtl/oesb_ctrl.v
// Output enable control with traditional and sideband serial paths
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "oesb_defs.vh"

module oesb_ctrl (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        nrst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Device pins
	input  wire        iface_select_pin,
	input  wire        power_good_down_n,
	input  wire [12:5] out_enable_n,
	input  wire [1:0]  addr_strap_hi,
	input  wire [1:0]  addr_strap_lo,
	// Results
	output reg  [19:0] out_active,
	output reg  [7:0]  smbus_addr,
	output reg         powered_up
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire [12:5] pin_sync_reg;
	wire        sel_sync_reg;
	wire        pg_sync_reg;
	wire [3:0]  strap_sync_reg;

	oesb_sync #(
		.W       (8),
		.RST_VAL (`OESB_RST_PINS)
	) u_sync_pins (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.d_async  (out_enable_n),
		.sync_reg (pin_sync_reg)
	);

	oesb_sync #(
		.W       (1),
		.RST_VAL (`OESB_RST_SEL)
	) u_sync_sel (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.d_async  (iface_select_pin),
		.sync_reg (sel_sync_reg)
	);

	oesb_sync #(
		.W       (1),
		.RST_VAL (`OESB_RST_PG)
	) u_sync_pg (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.d_async  (power_good_down_n),
		.sync_reg (pg_sync_reg)
	);

	oesb_sync #(
		.W       (4),
		.RST_VAL (`OESB_RST_STRAP)
	) u_sync_strap (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.d_async  ({addr_strap_hi, addr_strap_lo}),
		.sync_reg (strap_sync_reg)
	);

	wire sb_mode = sel_sync_reg;
	wire sb_data = pin_sync_reg[`OESB_PIN_DATA];
	wire sb_clk  = pin_sync_reg[`OESB_PIN_CLK];
	wire sb_load = pin_sync_reg[`OESB_PIN_LOAD];

	// ----------------------------------------------------------------
	// Strap decode and start-up latch
	// ----------------------------------------------------------------
	reg [7:0] addr_dec;

	always @* begin
		case (strap_sync_reg)
			{`OESB_STRAP_L, `OESB_STRAP_L}: addr_dec = `OESB_ADDR_LL;
			{`OESB_STRAP_L, `OESB_STRAP_M}: addr_dec = `OESB_ADDR_LM;
			{`OESB_STRAP_L, `OESB_STRAP_H}: addr_dec = `OESB_ADDR_LH;
			{`OESB_STRAP_M, `OESB_STRAP_L}: addr_dec = `OESB_ADDR_ML;
			{`OESB_STRAP_M, `OESB_STRAP_M}: addr_dec = `OESB_ADDR_MM;
			{`OESB_STRAP_M, `OESB_STRAP_H}: addr_dec = `OESB_ADDR_MH;
			{`OESB_STRAP_H, `OESB_STRAP_L}: addr_dec = `OESB_ADDR_HL;
			{`OESB_STRAP_H, `OESB_STRAP_M}: addr_dec = `OESB_ADDR_HM;
			default:                        addr_dec = `OESB_ADDR_HH;
		endcase
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			powered_up <= 1'b0;
			smbus_addr <= `OESB_RST_ADDR;
		end else if (pg_sync_reg && !powered_up) begin
			// Straps are caught only on the first power good high
			powered_up <= 1'b1;
			smbus_addr <= addr_dec;
		end
	end

	// ----------------------------------------------------------------
	// Sideband shift and output registers
	// ----------------------------------------------------------------
	wire       clk_rise;
	wire       load_fall;
	reg [19:0] shift_reg;
	reg [19:0] outreg_reg;

	oesb_edge u_edge_clk (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.level   (sb_clk),
		.rise    (clk_rise),
		.fall    ()
	);

	oesb_edge u_edge_load (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.level   (sb_load),
		.rise    (),
		.fall    (load_fall)
	);

	// Runs regardless of power good
	wire sb_shift = sb_mode && sb_load && clk_rise;
	wire sb_xfer  = sb_mode && load_fall;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			shift_reg     <= `OESB_RST_SHIFT;
			outreg_reg    <= `OESB_RST_OUTREG;
		end else begin
			if (sb_shift)
				// New bit enters at the top; after twenty the first sits at bit 0
				shift_reg <= {sb_data, shift_reg[19:1]};
			if (sb_xfer)
				outreg_reg <= shift_reg;
		end
	end

	// ----------------------------------------------------------------
	// APB register file
	// ----------------------------------------------------------------
	reg [19:0] smb_en_reg;
	reg [19:0] mask_reg;
	reg [19:0] smb_en_next;
	reg [19:0] mask_next;
	reg [31:0] rd_data;
	reg        rd_err;
	reg        is_mask;

	wire       addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000);
	wire [7:0] idx     = paddr[9:2];
	wire       access  = psel && penable && pready;

	always @* begin
		rd_data = 32'h00000000;
		rd_err  = 1'b0;
		is_mask = 1'b0;
		if (!addr_ok)
			rd_err = 1'b1;
		else begin
			case (idx)
				`OESB_IDX_EN0:   rd_data = {24'h000000, smb_en_reg[7:0]};
				`OESB_IDX_EN1:   rd_data = {24'h000000, smb_en_reg[15:8]};
				`OESB_IDX_EN2:   rd_data = {28'h0000000, smb_en_reg[19:16]};
				`OESB_IDX_MODE:  rd_data = {31'h00000000, sb_mode};
				`OESB_IDX_MASK0: begin
					is_mask = 1'b1;
					rd_data = {24'h000000, mask_reg[7:0]};
				end
				`OESB_IDX_MASK1: begin
					is_mask = 1'b1;
					rd_data = {24'h000000, mask_reg[15:8]};
				end
				`OESB_IDX_MASK2: begin
					is_mask = 1'b1;
					rd_data = {28'h0000000, mask_reg[19:16]};
				end
				default:         rd_err = 1'b1;
			endcase
		end
		if (is_mask && !pg_sync_reg) begin
			rd_err  = 1'b1;
			rd_data = 32'h00000000;
		end
	end

	always @* begin
		smb_en_next = smb_en_reg;
		mask_next   = mask_reg;
		if (access && pwrite && !pslverr) begin
			case (idx)
				`OESB_IDX_EN0:   smb_en_next[7:0]   = pwdata[7:0];
				`OESB_IDX_EN1:   smb_en_next[15:8]  = pwdata[7:0];
				`OESB_IDX_EN2:   smb_en_next[19:16] = pwdata[3:0];
				`OESB_IDX_MASK0: mask_next[7:0]     = pwdata[7:0];
				`OESB_IDX_MASK1: mask_next[15:8]    = pwdata[7:0];
				`OESB_IDX_MASK2: mask_next[19:16]   = pwdata[3:0];
				default:         smb_en_next = smb_en_reg;
			endcase
		end
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			smb_en_reg <= `OESB_RST_EN;
			mask_reg   <= `OESB_RST_MASK;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
		end else begin
			smb_en_reg <= smb_en_next;
			mask_reg   <= mask_next;
			// One wait state: answer in the second access cycle
			pready     <= psel && penable && !pready;
			pslverr    <= psel && penable && !pready && rd_err;
			if (psel && penable && !pready && !pwrite)
				prdata <= rd_data;
			else if (access)
				prdata <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Enable decision and shared sync stage
	// ----------------------------------------------------------------
	reg [19:0] pin_en;
	reg [19:0] decide;
	reg [19:0] stage_reg;
	integer    i;

	always @* begin
		pin_en = 20'hfffff;
		for (i = `OESB_PIN_LO; i <= `OESB_PIN_HI; i = i + 1)
			pin_en[i] = !pin_sync_reg[i];
		if (sb_mode)
			decide = outreg_reg | mask_reg;
		else
			decide = smb_en_reg & pin_en;
		if (!pg_sync_reg)
			decide = 20'h00000;
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stage_reg  <= 20'h00000;
			out_active <= 20'h00000;
		end else begin
			// Both paths meet here so each change lands on one edge
			stage_reg  <= decide;
			out_active <= stage_reg;
		end
	end

endmodule

// ----------------------------------------------------------------
// Two-stage synchroniser for inputs from outside the clock domain
// ----------------------------------------------------------------
module oesb_sync #(
	parameter         W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         nrst,
	// Asynchronous level in, synchronised level out
	input  wire [W-1:0] d_async,
	output reg  [W-1:0] sync_reg
);

	reg [W-1:0] meta_reg;

	// Nothing but the second stage reads the first
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= d_async;
			sync_reg <= meta_reg;
		end
	end

endmodule

// ----------------------------------------------------------------
// Edge finder on a synchronised level
// ----------------------------------------------------------------
module oesb_edge (
	// Clock and reset
	input  wire clk_sys,
	input  wire nrst,
	// Level in, one-cycle pulses out
	input  wire level,
	output wire rise,
	output wire fall
);

	reg level_d_reg;

	// Resets to the pulled-down idle level, so no false edge
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			level_d_reg <= `OESB_RST_LEVEL;
		else
			level_d_reg <= level;
	end

	assign rise = level && !level_d_reg;
	assign fall = !level && level_d_reg;

endmodule

`default_nettype wire

// ### test/oesb_ctrl_props.sv
// Port-level checks for the output enable block
`timescale 1ns/1ps
`default_nettype none
module oesb_ctrl_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and results
	input wire logic        iface_select_pin,
	input wire logic        power_good_down_n,
	input wire logic [12:5] out_enable_n,
	input wire logic [19:0] out_active,
	input wire logic [7:0]  smbus_addr,
	input wire logic        powered_up
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
	property p_rdy_cause; $rose(pready) |-> $past(psel && penable); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("pslverr outside pready");
	property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("prdata not zero");
	property p_pd_low; !power_good_down_n [*8] |-> out_active == 20'h0; endproperty
	a_pd_low: assert property (p_pd_low) else $error("output on in power down");
	property p_pin_off; (!iface_select_pin && out_enable_n[7]) [*8] |-> !out_active[7]; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin high left output on");
	property p_addr_zero; !powered_up |-> smbus_addr == 8'h00; endproperty
	a_addr_zero: assert property (p_addr_zero) else $error("address before power good");
	property p_up_hold; powered_up |=> powered_up; endproperty
	a_up_hold: assert property (p_up_hold) else $error("powered_up dropped");
	property p_up_cause; $rose(powered_up) |-> $past(power_good_down_n); endproperty
	a_up_cause: assert property (p_up_cause) else $error("start without power good");
	property p_addr_keep; powered_up && $past(powered_up) |-> $stable(smbus_addr); endproperty
	a_addr_keep: assert property (p_addr_keep) else $error("address changed");
	c_err: cover property (pslverr);
	c_up: cover property ($rose(powered_up));
	c_sb: cover property (iface_select_pin && power_good_down_n && out_active != 20'h0);
endmodule
`default_nettype wire

// ### test/oesb_ctrl_tb.sv
// Self-checking bench for the output enable block
`timescale 1ns/1ps
`default_nettype none
module oesb_ctrl_tb;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic        iface_sel = 1'b0;
	logic        pg_n = 1'b0;
	logic [7:0]  pins = 8'h00;
	logic [1:0]  s_hi = 2'h0;
	logic [1:0]  s_lo = 2'h0;
	logic [31:0] seed = 32'h0000b412;
	logic [31:0] rd;
	logic        er;
	logic [19:0] en, w, m;
	int          error_cnt = 0;
	int          n_checks = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, powered_up;
	wire  [19:0] out_active;
	wire  [7:0]  smbus_addr;
	wire  [12:5] oe_n = {pins[7:6], u_host.sb_load, pins[4:2], u_host.sb_clk, u_host.sb_data};
	logic [7:0]  addr_tab [9] = '{8'hd8, 8'hda, 8'hde, 8'hc2, 8'hc4, 8'hc6, 8'hca, 8'hcc, 8'hce};
	oesb_host u_host ();
	oesb_ctrl u_oesb_ctrl (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.iface_select_pin(iface_sel), .power_good_down_n(pg_n), .out_enable_n(oe_n), .addr_strap_hi(s_hi),
		.addr_strap_lo(s_lo), .out_active(out_active), .smbus_addr(smbus_addr), .powered_up(powered_up));
	initial forever #2.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [19:0] f_trad(input logic [19:0] e, input logic [12:5] p);
		return e & ~{7'h00, p, 5'h00};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr3(input logic [7:0] b, input logic [19:0] v);
		for (int i = 0; i < 3; i++)
			apb(1'b1, b + 8'(i), ({12'h000, v} >> (8 * i)) & 32'h0000_00ff);
	endtask
	task automatic rst();
		nrst <= 1'b0;
		wt(3);
		nrst <= 1'b1;
	endtask
	task results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 9; i++) begin
			pg_n <= 1'b0;
			s_hi <= 2'(i / 3);
			s_lo <= 2'(i % 3);
			rst();
			wt(4);
			chk(smbus_addr, 32'h0);
			pg_n <= 1'b1;
			wt(8);
			chk(smbus_addr, addr_tab[i]);
			s_hi <= 2'(i % 3);
			wt(6);
			chk(smbus_addr, addr_tab[i]);
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'(i), 32'h0);
			chk(rd, i == 2 ? 32'h0f : 32'hff);
		end
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0);
		chk(er, 32'h0);
		apb(1'b0, 8'h03, 32'h0);
		chk(er, 32'h1);
		repeat (6) begin
			en = 20'(xs());
			wr3(8'h00, en);
			pins <= 8'(xs());
			wt(10);
			chk(out_active, f_trad(en, oe_n));
		end
		pg_n <= 1'b0;
		iface_sel <= 1'b1;
		wt(8);
		chk(out_active, 32'h0);
		apb(1'b1, 8'h08, 32'h1);
		chk(er, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1);
		w = 20'(xs());
		u_host.shift(w);
		@(posedge clk_sys);
		pg_n <= 1'b1;
		wt(3);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0);
		m = 20'(xs() & xs());
		wr3(8'h08, m);
		apb(1'b0, 8'h0a, 32'h0);
		chk(rd, {28'h0, m[19:16]});
		wt(10);
		chk(out_active, w | m);
		u_host.noise();
		wt(10);
		chk(out_active, w | m);
		pins <= 8'(xs());
		w = 20'(xs());
		u_host.shift(w);
		wt(10);
		chk(out_active, w | m);
		iface_sel <= 1'b0;
		wt(10);
		chk(out_active, f_trad(en, oe_n));
		rst();
		wt(2);
		chk({powered_up, out_active}, 32'h0);
		iface_sel <= 1'b1;
		wt(10);
		chk(out_active, 32'h000fffff);
		results();
	end
	initial begin
		#200000;
		error_cnt++;
		results();
	end
endmodule
bind oesb_ctrl oesb_ctrl_props u_props (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .iface_select_pin(iface_select_pin),
	.power_good_down_n(power_good_down_n), .out_enable_n(out_enable_n), .out_active(out_active),
	.smbus_addr(smbus_addr), .powered_up(powered_up));
`default_nettype wire

// ### test/oesb_host.sv
// Host model driving the three sideband pins
`timescale 1ns/1ps
`default_nettype none
module oesb_host;
	logic sb_data = 1'b0;
	logic sb_clk  = 1'b0;
	logic sb_load = 1'b0;
	// One bit per 160 ns link period
	task automatic bit_out(input logic d);
		sb_data = d;
		#80 sb_clk = 1'b1;
		#80 sb_clk = 1'b0;
	endtask
	task automatic shift(input logic [19:0] w);
		#3 sb_load = 1'b1;
		for (int i = 0; i < 20; i++)
			bit_out(w[i]);
		sb_data = 1'b0;
		#80 sb_load = 1'b0;
	endtask
	// Activity with load low, to be ignored
	task automatic noise();
		repeat (6) bit_out(~sb_data);
		sb_data = 1'b0;
	endtask
endmodule
`default_nettype wire
